// ===== verilog/irq_gate_pkg.sv
// constants, register map and carrier types of the interrupt enable gating block
package irq_gate_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] ADDR_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_PERIPHERAL_ENABLE_ONE = 8'h04;
  localparam logic [7:0] ADDR_PERIPHERAL_ENABLE_TWO = 8'h08;
  localparam logic [7:0] ADDR_PERIPHERAL_FLAG_ONE = 8'h0c;
  localparam logic [7:0] ADDR_PERIPHERAL_FLAG_TWO = 8'h10;
  localparam logic [7:0] ADDR_PER_PIN_CHANGE_ENABLES = 8'h14;
  localparam logic [7:0] ADDR_PIN_CHANGE_LATCH = 8'h18;
  localparam logic [7:0] ADDR_EDGE_SELECT = 8'h1c;
  localparam logic [7:0] ADDR_SOURCE_STATUS = 8'h20;

  // interrupt_control field positions
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int PERIPHERAL_GROUP_ENABLE_BIT = 6;
  localparam int TIMER_ZERO_OVERFLOW_ENABLE_BIT = 5;
  localparam int EXT_PIN_IRQ_ENABLE_BIT = 4;
  localparam int PIN_CHANGE_ENABLE_BIT = 3;
  localparam int TIMER_ZERO_OVERFLOW_FLAG_BIT = 2;
  localparam int EXT_PIN_IRQ_FLAG_BIT = 1;
  localparam int PIN_CHANGE_FLAG_BIT = 0;

  // peripheral_enable_one / flag one positions
  localparam int ADC_DONE_BIT = 6;
  localparam int SERIAL_COLLISION_BIT = 5;
  localparam int SERIAL_PORT_BIT = 4;
  localparam int CAPCOMP_TWO_BIT = 3;
  localparam int CAPCOMP_ONE_BIT = 2;
  localparam int TIMER_TWO_BIT = 1;
  localparam int TIMER_ONE_BIT = 0;

  // peripheral_enable_two / flag two positions
  localparam int DESATURATION_BIT = 7;
  localparam int OVERTEMP_BIT = 4;
  localparam int OUTPUT_OVERVOLT_BIT = 3;
  localparam int GATE_DRIVE_UNDERVOLT_BIT = 2;
  localparam int INPUT_OVERVOLT_BIT = 1;
  localparam int INPUT_UNDERVOLT_BIT = 0;

  // edge_select field
  localparam int EXT_EDGE_RISING_BIT = 0;

  // implemented bits; the rest read zero and ignore writes
  localparam logic [7:0] PERIPHERAL_ONE_MASK = 8'h7f;
  localparam logic [7:0] PERIPHERAL_TWO_MASK = 8'h9f;
  localparam logic [7:0] CONTROL_ENABLE_MASK = 8'hf8;

  // reset values
  localparam logic [7:0] INTERRUPT_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PERIPHERAL_ENABLE_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] PIN_ENABLE_RESET = 8'h00;
  localparam logic [7:0] EDGE_SELECT_RESET = 8'h01;

  // address loaded into the program counter when an interrupt is taken
  localparam logic [15:0] IRQ_VECTOR = 16'h0004;

  localparam int PIN_COUNT = 8;

  // one-cycle event pulses from the peripherals, same clock
  typedef struct packed {
    logic [7:0] group_one;
    logic [7:0] group_two;
  } periph_events_s;

  // hand-shake with the core
  typedef struct packed {
    logic irq;
    logic [15:0] vector;
  } core_request_s;

endpackage

// ===== verilog/sticky_flags.sv
// row of sticky flags: hardware set wins over a software write
`timescale 1ns/10ps
module sticky_flags #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] MASK = '1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // set pulses and software load
  input wire logic [WIDTH-1:0] set_in,
  input wire logic write_in,
  input wire logic [WIDTH-1:0] wdata_in,
  // state
  output logic [WIDTH-1:0] flags_out
);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      flags_out <= RESET_VALUE & MASK;
    end else if (write_in) begin
      // an event landing on the clearing write is kept
      flags_out <= (wdata_in | set_in) & MASK;
    end else begin
      flags_out <= (flags_out | set_in) & MASK;
    end
  end

endmodule // sticky_flags

// ===== verilog/irq_enable_gating.sv
// interrupt enable and flag gating with an apb register slave
// Behaviour
// - bit 7 global enable; when clear, no interrupt reaches the core.
// - bit 6 peripheral group enable gates every peripheral source.
// - bit 5 enables the timer-0 overflow interrupt.
// - bit 4 enables the external pin interrupt.
// - bit 3 enables pin change; each pin also needs its own enable.
// - bit 2 set on timer-0 rollover, held until software writes zero.
// - bit 1 set on external pin edge, held until software clears it.
// - bit 0 shows whether any enabled pin has changed state.
// - enable one bits 6,5,4: adc, serial collision, serial port.
// - enable one bits 3,2: second and first capture/compare.
// - enable one bits 1,0: timer-2, timer-1; enables reset to zero.
// - unimplemented enable bits ignore writes and read zero.
// - enable two bit 7 enables desaturation detection.
// - enable two bit 4 enables overtemperature.
// - enable two bit 3 enables output overvoltage.
// - enable two bit 2 enables gate drive undervoltage lockout.
// - enable two bit 1 enables input overvoltage lockout.
// - enable two bit 0 enables input undervoltage lockout.
// - flags other than the pin change latches set on their condition regardless of any enable.
// - taking an interrupt clears global enable and presents vector 0004h.
`timescale 1ns/10ps
module irq_enable_gating
  import irq_gate_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // apb slave
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // event sources on this clock
  input wire logic timer_zero_rollover_in,
  input wire periph_events_s periph_events_in,
  // device pins, asynchronous
  input wire logic ext_irq_pin_in,
  input wire logic [PIN_COUNT-1:0] change_pins_in,
  // core side
  input wire logic irq_taken_in,
  output core_request_s core_request_out
);

  // enables held in interrupt_control bits 7..3
  logic [7:0] control_enables;
  logic [7:0] peripheral_enable_one;
  logic [7:0] peripheral_enable_two;
  logic [PIN_COUNT-1:0] per_pin_change_enables;
  logic [7:0] edge_select;

  // flags
  logic [1:0] core_flags;
  logic [7:0] peripheral_flag_one;
  logic [7:0] peripheral_flag_two;
  logic [PIN_COUNT-1:0] pin_change_latch;

  // bus decode
  logic setup_phase;
  logic write_access;
  logic hit_control;
  logic hit_enable_one;
  logic hit_enable_two;
  logic hit_flag_one;
  logic hit_flag_two;
  logic hit_pin_enables;
  logic hit_pin_latch;
  logic hit_edge;
  logic hit_status;
  logic hit_any;
  logic [7:0] wbyte;
  logic [7:0] next_rdata;

  // pin synchronisers and history
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic [PIN_COUNT-1:0] pins_meta;
  logic [PIN_COUNT-1:0] pins_sync;
  logic [PIN_COUNT-1:0] pins_prev;
  logic ext_edge;
  logic [PIN_COUNT-1:0] pin_changed;

  // gating terms
  logic global_irq_enable;
  logic peripheral_group_enable;
  logic timer_zero_overflow_enable;
  logic ext_pin_irq_enable;
  logic pin_change_enable;
  logic timer_zero_overflow_flag;
  logic ext_pin_irq_flag;
  logic pin_change_flag;
  logic [7:0] interrupt_control;
  logic [7:0] source_status;
  logic core_term;
  logic periph_term;
  logic next_irq;

  // ---------------------------------------------------------------- apb
  assign setup_phase = psel_in && !penable_in;
  // only the low byte lane carries register data
  assign write_access = psel_in && penable_in && pwrite_in && pstrb_in[0];
  assign wbyte = pwdata_in[7:0];

  assign hit_control = (paddr_in == ADDR_INTERRUPT_CONTROL);
  assign hit_enable_one = (paddr_in == ADDR_PERIPHERAL_ENABLE_ONE);
  assign hit_enable_two = (paddr_in == ADDR_PERIPHERAL_ENABLE_TWO);
  assign hit_flag_one = (paddr_in == ADDR_PERIPHERAL_FLAG_ONE);
  assign hit_flag_two = (paddr_in == ADDR_PERIPHERAL_FLAG_TWO);
  assign hit_pin_enables = (paddr_in == ADDR_PER_PIN_CHANGE_ENABLES);
  assign hit_pin_latch = (paddr_in == ADDR_PIN_CHANGE_LATCH);
  assign hit_edge = (paddr_in == ADDR_EDGE_SELECT);
  assign hit_status = (paddr_in == ADDR_SOURCE_STATUS);
  assign hit_any = hit_control || hit_enable_one || hit_enable_two || hit_flag_one ||
                   hit_flag_two || hit_pin_enables || hit_pin_latch || hit_edge ||
                   hit_status;

  // zero wait states: data is registered during setup, access always ready
  assign pready_out = 1'b1;

  always_comb begin
    next_rdata = 8'h00;
    case (1'b1)
      hit_control: next_rdata = interrupt_control;
      hit_enable_one: next_rdata = peripheral_enable_one;
      hit_enable_two: next_rdata = peripheral_enable_two;
      hit_flag_one: next_rdata = peripheral_flag_one;
      hit_flag_two: next_rdata = peripheral_flag_two;
      hit_pin_enables: next_rdata = per_pin_change_enables;
      hit_pin_latch: next_rdata = pin_change_latch;
      hit_edge: next_rdata = edge_select;
      hit_status: next_rdata = source_status;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata_out <= {24'h00_0000, next_rdata};
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pslverr_out <= 1'b0;
    end else if (setup_phase) begin
      pslverr_out <= !hit_any;
    end
  end

  // ---------------------------------------------------------- enables
  // core entry clears the global enable ahead of a same-cycle write
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      control_enables <= INTERRUPT_CONTROL_RESET & CONTROL_ENABLE_MASK;
    end else begin
      if (write_access && hit_control) begin
        control_enables <= wbyte & CONTROL_ENABLE_MASK;
      end
      if (irq_taken_in) begin
        control_enables[GLOBAL_IRQ_ENABLE_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      peripheral_enable_one <= PERIPHERAL_ENABLE_RESET;
    end else if (write_access && hit_enable_one) begin
      peripheral_enable_one <= wbyte & PERIPHERAL_ONE_MASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      peripheral_enable_two <= PERIPHERAL_ENABLE_RESET;
    end else if (write_access && hit_enable_two) begin
      peripheral_enable_two <= wbyte & PERIPHERAL_TWO_MASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      per_pin_change_enables <= PIN_ENABLE_RESET;
    end else if (write_access && hit_pin_enables) begin
      per_pin_change_enables <= wbyte;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      edge_select <= EDGE_SELECT_RESET;
    end else if (write_access && hit_edge) begin
      edge_select <= wbyte & 8'h01;
    end
  end

  // ------------------------------------------------------ pin capture
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= ext_irq_pin_in;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pins_meta <= '0;
      pins_sync <= '0;
      pins_prev <= '0;
    end else begin
      pins_meta <= change_pins_in;
      pins_sync <= pins_meta;
      pins_prev <= pins_sync;
    end
  end

  // a pin already high at reset release shows one edge: the history starts at zero
  assign ext_edge = edge_select[EXT_EDGE_RISING_BIT] ? (ext_sync && !ext_prev)
                                                     : (!ext_sync && ext_prev);
  assign pin_changed = (pins_sync ^ pins_prev) & per_pin_change_enables;

  // ------------------------------------------------------------ flags
  // core and peripheral flags set without looking at any enable
  sticky_flags #(
    .WIDTH(2),
    .MASK(2'b11),
    .RESET_VALUE(2'b00)
  ) core_flag_row (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .set_in({timer_zero_rollover_in, ext_edge}),
    .write_in(write_access && hit_control),
    .wdata_in(wbyte[TIMER_ZERO_OVERFLOW_FLAG_BIT:EXT_PIN_IRQ_FLAG_BIT]),
    .flags_out(core_flags)
  );

  sticky_flags #(
    .WIDTH(8),
    .MASK(PERIPHERAL_ONE_MASK),
    .RESET_VALUE(FLAG_RESET)
  ) flag_one_row (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .set_in(periph_events_in.group_one),
    .write_in(write_access && hit_flag_one),
    .wdata_in(wbyte),
    .flags_out(peripheral_flag_one)
  );

  sticky_flags #(
    .WIDTH(8),
    .MASK(PERIPHERAL_TWO_MASK),
    .RESET_VALUE(FLAG_RESET)
  ) flag_two_row (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .set_in(periph_events_in.group_two),
    .write_in(write_access && hit_flag_two),
    .wdata_in(wbyte),
    .flags_out(peripheral_flag_two)
  );

  // per-pin change latches, the pin change flag is their OR
  sticky_flags #(
    .WIDTH(PIN_COUNT),
    .MASK(8'hff),
    .RESET_VALUE(FLAG_RESET)
  ) pin_latch_row (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .set_in(pin_changed),
    .write_in(write_access && hit_pin_latch),
    .wdata_in(wbyte),
    .flags_out(pin_change_latch)
  );

  // ----------------------------------------------------------- gating
  assign global_irq_enable = control_enables[GLOBAL_IRQ_ENABLE_BIT];
  assign peripheral_group_enable = control_enables[PERIPHERAL_GROUP_ENABLE_BIT];
  assign timer_zero_overflow_enable = control_enables[TIMER_ZERO_OVERFLOW_ENABLE_BIT];
  assign ext_pin_irq_enable = control_enables[EXT_PIN_IRQ_ENABLE_BIT];
  assign pin_change_enable = control_enables[PIN_CHANGE_ENABLE_BIT];
  assign timer_zero_overflow_flag = core_flags[1];
  assign ext_pin_irq_flag = core_flags[0];
  // derived, so writes to this position have no effect
  assign pin_change_flag = |pin_change_latch;

  assign interrupt_control = {control_enables[7:3], timer_zero_overflow_flag,
                              ext_pin_irq_flag, pin_change_flag};

  assign core_term = (timer_zero_overflow_enable && timer_zero_overflow_flag) ||
                     (ext_pin_irq_enable && ext_pin_irq_flag) ||
                     (pin_change_enable && pin_change_flag);
  assign periph_term = peripheral_group_enable &&
                       (|(peripheral_enable_one & peripheral_flag_one) ||
                        |(peripheral_enable_two & peripheral_flag_two));
  assign next_irq = global_irq_enable && (core_term || periph_term);

  // gated view for firmware polling: bit0 core, bit1 peripheral, bit2 request
  assign source_status = {5'b00000, next_irq, periph_term, core_term};

  // request is registered; taking it drops it on the following edge
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      core_request_out.irq <= 1'b0;
    end else begin
      core_request_out.irq <= next_irq && !irq_taken_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      core_request_out.vector <= IRQ_VECTOR;
    end else begin
      core_request_out.vector <= IRQ_VECTOR;
    end
  end

endmodule // irq_enable_gating

// ===== testbench/irq_gate_assertions.sv
// port-level checker for the interrupt enable gating block
`timescale 1ns/10ps
module irq_gate_assertions
  import irq_gate_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // apb slave
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic pslverr_out,
  // events and core
  input wire logic timer_zero_rollover_in,
  input wire logic irq_taken_in,
  input wire core_request_s core_request_out
);
  logic ctl_wr;
  logic rd_setup;
  logic [7:2] ctl;
  assign ctl_wr = psel_in && penable_in && pwrite_in && pstrb_in[0] && paddr_in == 8'h00;
  assign rd_setup = psel_in && !penable_in && !pwrite_in;
  // shadow of enables and timer flag; hardware set and taken beat a write
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ctl <= '0;
    end else begin
      if (ctl_wr) ctl <= pwdata_in[7:2];
      if (irq_taken_in) ctl[7] <= 1'b0;
      if (timer_zero_rollover_in) ctl[2] <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  a_vector_fixed: assert property (core_request_out.vector == 16'h0004)
    else $error("vector is not the handler address");
  a_taken_drops_irq: assert property (irq_taken_in |=> !core_request_out.irq)
    else $error("request stayed up after the core took it");
  a_irq_needs_global: assert property (core_request_out.irq |-> $past(ctl[7]))
    else $error("request raised with global enable clear");
  a_timer_raises_irq: assert property ((timer_zero_rollover_in && ctl[7] && ctl[5] && !ctl_wr
    && !irq_taken_in) ##1 (!ctl_wr && !irq_taken_in) |=> core_request_out.irq)
    else $error("enabled timer overflow gave no request");
  a_control_readback: assert property (rd_setup && paddr_in == 8'h00
    |=> prdata_out[7:2] == $past(ctl))
    else $error("control read differs from expected enables and flag");
  a_enone_reserved: assert property (rd_setup && paddr_in == 8'h04 |=> prdata_out[7] == 1'b0)
    else $error("unused enable one bit reads set");
  a_entwo_reserved: assert property (rd_setup && paddr_in == 8'h08 |=> prdata_out[6:5] == 2'b00)
    else $error("unused enable two bits read set");
  a_upper_zero: assert property (prdata_out[31:8] == 24'h0)
    else $error("read data upper lanes not zero");
  a_unmapped_error: assert property (psel_in && !penable_in && paddr_in > 8'h20 |=> pslverr_out)
    else $error("unmapped access without error");
  c_taken: cover property (core_request_out.irq && irq_taken_in);
  c_ctl_read: cover property (rd_setup && paddr_in == 8'h00);
  c_unmapped: cover property (psel_in && penable_in && pslverr_out);
endmodule // irq_gate_assertions

bind irq_enable_gating irq_gate_assertions i_checker (.clk_in, .srst_in, .paddr_in, .psel_in,
  .penable_in, .pwrite_in, .pwdata_in, .pstrb_in, .prdata_out, .pslverr_out,
  .timer_zero_rollover_in, .irq_taken_in, .core_request_out);

// ===== testbench/core_model.sv
// processor core stand-in: enters the handler a chosen number of cycles after a request
`timescale 1ns/10ps
module core_model
  import irq_gate_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // request side
  input wire core_request_s core_request_in,
  input wire logic [3:0] delay_in,
  output logic irq_taken_out
);
  logic [3:0] wait_cnt;
  // one taken pulse per request; a slow core leaves the request pending longer
  always_ff @(posedge clk_in) begin
    if (srst_in || !core_request_in.irq || irq_taken_out) begin
      wait_cnt <= '0;
      irq_taken_out <= 1'b0;
    end else if (wait_cnt == delay_in) begin
      irq_taken_out <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // core_model

// ===== testbench/irq_enable_gating_tb.sv
// self-checking bench for the interrupt enable gating block
`timescale 1ns/10ps
module irq_enable_gating_tb
  import irq_gate_pkg::*;
;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] paddr_in = '0;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, pready_out, pslverr_out;
  logic [31:0] pwdata_in = '0, prdata_out;
  logic [3:0] pstrb_in = 4'h1;
  logic timer_zero_rollover_in = 1'b0, ext_irq_pin_in = 1'b0, irq_taken_in;
  logic [PIN_COUNT-1:0] change_pins_in = '0;
  logic [3:0] core_delay = 4'h0;
  periph_events_s periph_events_in = '0;
  core_request_s core_request_out;
  int n_errors = 0, checked = 0, n_taken = 0;

  initial begin
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (irq_taken_in === 1'b1) n_taken <= n_taken + 1;
  end

  irq_enable_gating i_dut (.clk_in, .srst_in, .paddr_in, .psel_in, .penable_in, .pwrite_in,
    .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .timer_zero_rollover_in,
    .periph_events_in, .ext_irq_pin_in, .change_pins_in, .irq_taken_in, .core_request_out);
  core_model i_core (.clk_in, .srst_in, .core_request_in(core_request_out),
    .delay_in(core_delay), .irq_taken_out(irq_taken_in));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
    output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= {24'h0, d};
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_errors++;
      final_report();
    end
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(what, r, exp);
  endtask
  task automatic fire(input logic tmr, input logic [15:0] ev);
    @(posedge clk_in);
    timer_zero_rollover_in <= tmr;
    periph_events_in <= ev;
    @(posedge clk_in);
    timer_zero_rollover_in <= 1'b0;
    periph_events_in <= '0;
  endtask
  task automatic expect_taken(input string what);
    int start;
    start = n_taken;
    for (int i = 0; i < 40 && n_taken == start; i++) @(posedge clk_in);
    chk(what, 32'(n_taken - start), 32'h1);
    if (n_taken == start) final_report();
  endtask
  // latency is at most four edges (pin synchronisers), so eight quiet cycles leave no doubt
  task automatic expect_quiet(input string what);
    logic seen;
    seen = 1'b0;
    repeat (8) begin
      @(posedge clk_in);
      seen = seen | core_request_out.irq;
    end
    chk(what, {31'h0, seen}, 32'h0);
  endtask

  task automatic t_reset_values;
    rd_chk("control", ADDR_INTERRUPT_CONTROL, 32'h0);
    rd_chk("enable one", ADDR_PERIPHERAL_ENABLE_ONE, 32'h0);
    rd_chk("enable two", ADDR_PERIPHERAL_ENABLE_TWO, 32'h0);
    chk("vector", {16'h0, core_request_out.vector}, 32'h4);
    $display("done reset values");
  endtask
  task automatic t_reserved_bits;
    logic [31:0] r;
    logic e;
    wr(ADDR_PERIPHERAL_ENABLE_ONE, 8'hff);
    rd_chk("enable one all", ADDR_PERIPHERAL_ENABLE_ONE, 32'h7f);
    wr(ADDR_PERIPHERAL_ENABLE_TWO, 8'hff);
    rd_chk("enable two all", ADDR_PERIPHERAL_ENABLE_TWO, 32'h9f);
    wr(ADDR_PERIPHERAL_ENABLE_ONE, 8'h00);
    wr(ADDR_PERIPHERAL_ENABLE_TWO, 8'h00);
    apb(1'b0, 8'h40, 8'h00, r, e);
    chk("unmapped error", {31'h0, e}, 32'h1);
    chk("unmapped data", r, 32'h0);
    $display("done reserved bits");
  endtask
  task automatic t_timer_path;
    core_delay <= 4'h0;
    wr(ADDR_INTERRUPT_CONTROL, 8'ha0);
    fire(1'b1, 16'h0);
    expect_taken("timer irq taken");
    rd_chk("control after timer", ADDR_INTERRUPT_CONTROL, 32'h24);
    // timer-0 count lives outside; firmware has reloaded it before this clear
    wr(ADDR_INTERRUPT_CONTROL, 8'h20);
    rd_chk("timer flag cleared", ADDR_INTERRUPT_CONTROL, 32'h20);
    fire(1'b1, 16'h0);
    expect_quiet("irq with global off");
    rd_chk("flag without global", ADDR_INTERRUPT_CONTROL, 32'h24);
    wr(ADDR_INTERRUPT_CONTROL, 8'h00);
    $display("done timer path");
  endtask
  task automatic t_periph_sources;
    logic [15:0] mask;
    logic [7:0] flag_addr;
    mask = {PERIPHERAL_ONE_MASK, PERIPHERAL_TWO_MASK};
    core_delay <= 4'h5;
    for (int i = 0; i < 16; i++) begin
      if (mask[i]) begin
        wr(i >= 8 ? ADDR_PERIPHERAL_ENABLE_ONE : ADDR_PERIPHERAL_ENABLE_TWO, 8'(1 << (i % 8)));
        wr(ADDR_INTERRUPT_CONTROL, 8'h80);
        fire(1'b0, 16'(1 << i));
        expect_quiet("peripheral without group enable");
        wr(ADDR_INTERRUPT_CONTROL, 8'hc0);
        // core waits five cycles, so the request is still gated on at this read
        rd_chk("gated status", ADDR_SOURCE_STATUS, 32'h06);
        expect_taken("peripheral irq taken");
        flag_addr = i >= 8 ? ADDR_PERIPHERAL_FLAG_ONE : ADDR_PERIPHERAL_FLAG_TWO;
        rd_chk("peripheral flag", flag_addr, 32'(1 << (i % 8)));
        wr(i >= 8 ? ADDR_PERIPHERAL_FLAG_ONE : ADDR_PERIPHERAL_FLAG_TWO, 8'h00);
        wr(i >= 8 ? ADDR_PERIPHERAL_ENABLE_ONE : ADDR_PERIPHERAL_ENABLE_TWO, 8'h00);
      end
    end
    wr(ADDR_INTERRUPT_CONTROL, 8'h00);
    $display("done peripheral sources");
  endtask
  task automatic t_ext_pin;
    core_delay <= 4'h2;
    wr(ADDR_INTERRUPT_CONTROL, 8'h90);
    ext_irq_pin_in <= 1'b1;
    expect_taken("external pin irq taken");
    rd_chk("external flag", ADDR_INTERRUPT_CONTROL, 32'h12);
    wr(ADDR_INTERRUPT_CONTROL, 8'h10);
    rd_chk("external flag cleared", ADDR_INTERRUPT_CONTROL, 32'h10);
    // falling edge mode: the pin drop must now set the flag
    wr(ADDR_EDGE_SELECT, 8'h00);
    ext_irq_pin_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rd_chk("falling edge flag", ADDR_INTERRUPT_CONTROL, 32'h12);
    wr(ADDR_INTERRUPT_CONTROL, 8'h00);
    wr(ADDR_EDGE_SELECT, 8'h01);
    $display("done external pin");
  endtask
  task automatic t_pin_change;
    wr(ADDR_PER_PIN_CHANGE_ENABLES, 8'h01);
    wr(ADDR_INTERRUPT_CONTROL, 8'h88);
    change_pins_in <= 8'h02;
    expect_quiet("disabled pin change");
    change_pins_in <= 8'h03;
    expect_taken("pin change irq taken");
    rd_chk("pin change flag", ADDR_INTERRUPT_CONTROL, 32'h09);
    wr(ADDR_PIN_CHANGE_LATCH, 8'h00);
    rd_chk("pin change flag cleared", ADDR_INTERRUPT_CONTROL, 32'h08);
    wr(ADDR_INTERRUPT_CONTROL, 8'h00);
    $display("done pin change");
  endtask

  initial begin
    repeat (12) @(posedge clk_in);
    srst_in <= 1'b0;
    t_reset_values();
    t_reserved_bits();
    t_timer_path();
    t_periph_sources();
    t_ext_pin();
    t_pin_change();
    final_report();
  end
endmodule // irq_enable_gating_tb
